// ---- logic/tcc_pkg.sv ----
// Constants, types and register map of the transfer controller counter block
package tcc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_SRC = 5'h00;
  localparam logic [4:0] OFS_DST = 5'h04;
  localparam logic [4:0] OFS_PCOUNT = 5'h08;
  localparam logic [4:0] OFS_BCOUNT = 5'h0C;
  localparam logic [4:0] OFS_MODE = 5'h10;
  localparam logic [4:0] OFS_ACT = 5'h14;
  localparam logic [4:0] OFS_SWV = 5'h18;
  localparam logic [4:0] OFS_STAT = 5'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int SIZE_BIT = 2;
  localparam int EACH_IRQ_BIT = 3;
  localparam int SW_EN_BIT = 7;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SWEND_BIT = 1;
  localparam int STAT_VEC_LSB = 16;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] ACT_RESET = 8'h00;
  localparam logic [7:0] SWV_RESET = 8'h00;
  localparam logic [15:0] VEC_BASE = 16'h0400;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_REPEAT = 2'b01,
    MODE_BLOCK = 2'b10,
    MODE_PROHIB = 2'b11
  } tcc_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_END = 2'b10
  } tcc_state_t;

  typedef struct packed {
    logic [23:0] src;
    logic [23:0] dst;
    logic word;
  } tcc_xfer_t;

endpackage

// ---- logic/tcc_core.sv ----
// Transfer controller counters, activation enables and software start
module tcc_core (
  input logic core_clk,
  input logic rst_b,
  input logic [tcc_pkg::ADDR_W-1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input logic [7:0] act_request,
  output logic [7:0] src_flag_clear,
  output logic cpu_irq,
  output logic [2:0] cpu_irq_source,
  output logic sw_end_irq,
  output logic xfer_valid,
  output tcc_pkg::tcc_xfer_t xfer,
  output logic [15:0] vector_address
);
  import tcc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_be(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Highest index wins, matching fixed source priority
  function automatic logic [2:0] pick_src(logic [7:0] pend);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (pend[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [23:0] src_q;
  logic [23:0] dst_q;
  logic [15:0] pcount_q;
  logic [15:0] bcount_q;
  tcc_mode_t mode_q;
  logic size_q;
  logic each_irq_q;
  logic [7:0] act_en_q;
  logic sw_en_q;
  logic [6:0] vec_q;
  logic sw_req_q;
  logic swend_q;
  tcc_state_t state_q;
  logic from_sw_q;
  logic [2:0] chan_q;
  logic done_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] clr_q;
  logic irq_q;
  logic [2:0] irq_src_q;
  logic xv_q;
  tcc_xfer_t xfer_q;
  logic [15:0] vaddr_q;

  logic [31:0] rd_mux;
  logic [31:0] wr_val;
  logic wr_take;
  logic wr_src;
  logic wr_dst;
  logic wr_pcount;
  logic wr_bcount;
  logic wr_mode;
  logic wr_act;
  logic wr_swv;
  logic [15:0] pcount_d;
  logic [15:0] bcount_d;
  logic act_last;
  logic count_done;
  logic [7:0] run_n;
  logic [15:0] full_n;
  logic [7:0] pend;
  logic keep;
  logic end_sw;
  logic end_irq;

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, answer on second edge
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      OFS_SRC: rd_mux = {8'h00, src_q};
      OFS_DST: rd_mux = {8'h00, dst_q};
      OFS_PCOUNT: rd_mux = {16'h0000, pcount_q};
      OFS_BCOUNT: rd_mux = {16'h0000, bcount_q};
      OFS_MODE: rd_mux = {28'h000_0000, each_irq_q, size_q, mode_q};
      OFS_ACT: rd_mux = {24'h00_0000, act_en_q};
      OFS_SWV: rd_mux = {24'h00_0000, sw_en_q, vec_q};
      OFS_STAT: rd_mux = {vaddr_q, 14'h0000, swend_q, state_q != ST_IDLE};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign wr_val = merge_be(rd_mux, avs_writedata, avs_byteenable);
  assign wr_take = avs_write && !wait_q;
  assign wr_src = wr_take && avs_address == OFS_SRC;
  assign wr_dst = wr_take && avs_address == OFS_DST;
  assign wr_pcount = wr_take && avs_address == OFS_PCOUNT;
  assign wr_bcount = wr_take && avs_address == OFS_BCOUNT;
  assign wr_mode = wr_take && avs_address == OFS_MODE;
  assign wr_act = wr_take && avs_address == OFS_ACT;
  assign wr_swv = wr_take && avs_address == OFS_SWV;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
      rdata_q <= rd_mux;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Addresses and configuration
  // ----------------------------------------------------------------
  // Evenness for word transfers is left to software, no check here
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_q <= 24'h00_0000;
      dst_q <= 24'h00_0000;
    end else begin
      if (wr_src) begin
        src_q <= wr_val[23:0];
      end
      if (wr_dst) begin
        dst_q <= wr_val[23:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MODE_NORMAL;
      size_q <= 1'b0;
      each_irq_q <= 1'b0;
    end else if (wr_mode) begin
      mode_q <= tcc_mode_t'(wr_val[MODE_LSB +: 2]);
      size_q <= wr_val[SIZE_BIT];
      each_irq_q <= wr_val[EACH_IRQ_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Counter stepping
  // ----------------------------------------------------------------
  // Decrement wraps, so a count loaded as zero runs the full range
  always_comb begin
    run_n = pcount_q[7:0] - 8'h01;
    full_n = pcount_q - 16'h0001;
    pcount_d = pcount_q;
    bcount_d = bcount_q;
    act_last = 1'b1;
    count_done = 1'b0;
    case (mode_q)
      MODE_REPEAT: begin
        pcount_d = {pcount_q[15:8], (run_n == 8'h00) ? pcount_q[15:8] : run_n};
      end
      MODE_BLOCK: begin
        pcount_d = {pcount_q[15:8], (run_n == 8'h00) ? pcount_q[15:8] : run_n};
        if (run_n != 8'h00) begin
          act_last = 1'b0;
        end else begin
          bcount_d = bcount_q - 16'h0001;
          count_done = bcount_d == 16'h0000;
        end
      end
      // Prohibited code runs as normal mode rather than hang
      default: begin
        pcount_d = full_n;
        count_done = full_n == 16'h0000;
      end
    endcase
  end

  // Bus write wins over an engine step in the same cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pcount_q <= 16'h0000;
      bcount_q <= 16'h0000;
    end else begin
      if (wr_pcount) begin
        pcount_q <= wr_val[15:0];
      end else if (state_q == ST_XFER) begin
        pcount_q <= pcount_d;
      end
      if (wr_bcount) begin
        bcount_q <= wr_val[15:0];
      end else if (state_q == ST_XFER) begin
        bcount_q <= bcount_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Activation engine
  // ----------------------------------------------------------------
  // Sources cleared last cycle are masked while their flag falls
  assign pend = act_request & act_en_q & ~clr_q;
  assign keep = each_irq_q || done_q;
  assign end_sw = state_q == ST_END && from_sw_q;
  assign end_irq = state_q == ST_END && !from_sw_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      from_sw_q <= 1'b0;
      chan_q <= 3'h0;
      done_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          done_q <= 1'b0;
          if (sw_req_q) begin
            from_sw_q <= 1'b1;
            state_q <= ST_XFER;
          end else if (pend != 8'h00) begin
            from_sw_q <= 1'b0;
            chan_q <= pick_src(pend);
            state_q <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (act_last) begin
            done_q <= count_done;
            state_q <= ST_END;
          end
        end
        ST_END: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Activation enables
  // ----------------------------------------------------------------
  // Bulk writes are legal only when sources are masked by software
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_en_q <= ACT_RESET;
    end else if (wr_act) begin
      act_en_q <= wr_val[7:0];
    end else if (end_irq && keep) begin
      act_en_q[chan_q] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Software start control
  // ----------------------------------------------------------------
  // Zero writes to the enable are dropped; hardware or a MODE write that clears swend_q clears it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_en_q <= 1'b0;
      vec_q <= SWV_RESET[6:0];
      sw_req_q <= 1'b0;
    end else begin
      if (wr_swv && !sw_en_q) begin
        vec_q <= wr_val[6:0];
      end
      if (wr_swv && wr_val[SW_EN_BIT] && !sw_en_q) begin
        sw_en_q <= 1'b1;
        sw_req_q <= 1'b1;
      end else if (end_sw && !keep) begin
        sw_en_q <= 1'b0;
      end else if (wr_mode && !wr_val[EACH_IRQ_BIT] && swend_q) begin
        sw_en_q <= 1'b0;
      end
      if (state_q == ST_IDLE && sw_req_q) begin
        sw_req_q <= 1'b0;
      end
    end
  end

  // Set wins over the clearing write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      swend_q <= 1'b0;
    end else if (end_sw && keep) begin
      swend_q <= 1'b1;
    end else if (wr_mode && !wr_val[EACH_IRQ_BIT]) begin
      swend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clr_q <= 8'h00;
      irq_q <= 1'b0;
      irq_src_q <= 3'h0;
      xv_q <= 1'b0;
      xfer_q <= '0;
      vaddr_q <= VEC_BASE;
    end else begin
      clr_q <= 8'h00;
      irq_q <= 1'b0;
      xv_q <= state_q == ST_XFER;
      xfer_q <= '{src: src_q, dst: dst_q, word: size_q};
      vaddr_q <= VEC_BASE + {8'h00, vec_q, 1'b0};
      if (end_irq && !keep) begin
        clr_q[chan_q] <= 1'b1;
      end
      if (end_irq && keep) begin
        irq_q <= 1'b1;
        irq_src_q <= chan_q;
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign src_flag_clear = clr_q;
  assign cpu_irq = irq_q;
  assign cpu_irq_source = irq_src_q;
  assign sw_end_irq = swend_q;
  assign xfer_valid = xv_q;
  assign xfer = xfer_q;
  assign vector_address = vaddr_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_step;
    state_q == ST_XFER;
  endsequence

  sequence s_end_sw_keep;
    end_sw && keep;
  endsequence

  a_normal_count: assert property (s_step and mode_q == MODE_NORMAL && !wr_pcount
    |=> pcount_q == $past(pcount_q) - 16'h0001) else $error("normal count did not step");
  a_half_split: assert property (s_step and mode_q == MODE_REPEAT && !wr_pcount
    |=> pcount_q[15:8] == $past(pcount_q[15:8])) else $error("reload half changed");
  a_repeat_reload: assert property (s_step and mode_q == MODE_REPEAT && pcount_q[7:0] == 8'h01 && !wr_pcount
    |=> pcount_q[7:0] == pcount_q[15:8] ##1 state_q == ST_IDLE) else $error("repeat reload wrong");
  a_block_run: assert property (s_step and mode_q == MODE_BLOCK && pcount_q[7:0] != 8'h01
    |=> state_q == ST_XFER) else $error("block ended early");
  a_block_count: assert property (s_step and mode_q == MODE_BLOCK && pcount_q[7:0] == 8'h01 && !wr_bcount
    |=> bcount_q == $past(bcount_q) - 16'h0001 && state_q == ST_END) else $error("block count wrong");
  a_no_start: assert property (state_q == ST_IDLE && !sw_req_q && pend == 8'h00
    |=> state_q == ST_IDLE) else $error("start without enable");
  a_act_clear: assert property (end_irq && keep && !wr_act
    |=> !act_en_q[$past(chan_q)] && cpu_irq) else $error("enable not cleared");
  a_act_keep: assert property (end_irq && !keep && !wr_act
    |=> act_en_q == $past(act_en_q) && src_flag_clear[$past(chan_q)]) else $error("enable lost");
  a_sw_set: assert property (wr_swv && wr_val[SW_EN_BIT] && !sw_en_q && state_q == ST_IDLE && pend == 8'h00
    |=> sw_en_q ##1 state_q == ST_XFER) else $error("software start missed");
  a_sw_clear: assert property (end_sw && !keep |=> !sw_en_q) else $error("soft enable kept");
  a_sw_hold: assert property (s_end_sw_keep |=> sw_en_q && sw_end_irq) else $error("soft enable lost");
  a_vec_lock: assert property (sw_en_q && wr_swv |=> vec_q == $past(vec_q)) else $error("vector changed");
  a_vec_addr: assert property (1'b1 |=> vector_address == VEC_BASE + {8'h00, $past(vec_q), 1'b0})
    else $error("vector address wrong");
  a_size_out: assert property (s_step |=> xfer_valid && xfer.word == $past(size_q))
    else $error("transfer size wrong");

endmodule

// ---- test/tcc_src_model.sv ----
// Behavioural model of the interrupt source flags beside the controller
module tcc_src_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] raise,
  input wire logic [7:0] drop,
  input wire logic [7:0] src_flag_clear,
  output logic [7:0] act_request
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Source flags
  // ----------------------------------------------------------------
  // Flag stays until cleared by the controller or by its owner
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_request <= 8'h00;
    end else begin
      act_request <= (act_request | raise) & ~src_flag_clear & ~drop;
    end
  end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the transfer controller counter block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tcc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] raise = 8'h00;
  logic [7:0] drop = 8'h00;
  logic [7:0] act_request, src_flag_clear;
  logic cpu_irq, sw_end_irq, xfer_valid, exp_word;
  logic [2:0] cpu_irq_source;
  tcc_xfer_t xfer;
  logic [15:0] vector_address;
  logic [31:0] rd, sa, da;
  logic [6:0] vec;
  int failures = 0;
  int tests_run = 0;
  int seed = 3;
  int n_xfer = 0;
  int n_irq = 0;

  always #2.5 core_clk = ~core_clk;

  tcc_core dut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .act_request(act_request),
    .src_flag_clear(src_flag_clear), .cpu_irq(cpu_irq), .cpu_irq_source(cpu_irq_source),
    .sw_end_irq(sw_end_irq), .xfer_valid(xfer_valid), .xfer(xfer), .vector_address(vector_address));

  tcc_src_model srcs (.core_clk(core_clk), .rst_b(rst_b), .raise(raise), .drop(drop),
    .src_flag_clear(src_flag_clear), .act_request(act_request));

  // ----------------------------------------------------------------
  // Checking tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] exp_vec(input logic [6:0] v);
    return VEC_BASE + {8'h00, v, 1'b0};
  endfunction

  always @(posedge core_clk) begin
    if (xfer_valid === 1'b1) begin
      n_xfer <= n_xfer + 1;
      chk({8'h00, xfer.src}, sa);
      chk({8'h00, xfer.dst}, da);
      chk(xfer.word, exp_word);
    end
    if (cpu_irq === 1'b1) begin
      n_irq <= n_irq + 1;
    end
  end

  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      failures++;
      finish_test();
    end
  endtask

  // Waits for a number of transfers, then lets END and its updates land
  task automatic wait_xfer(input int k);
    int target, n;
    target = n_xfer + k;
    n = 0;
    while (n_xfer < target && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 200) begin
      failures++;
      finish_test();
    end
    repeat (4) @(posedge core_clk);
  endtask

  task automatic irq_case(input logic [3:0] md, input logic [15:0] pc, input int nx,
                          input logic [15:0] epc, input logic [15:0] ebc, input logic keep);
    int i0;
    logic [2:0] s;
    s = $random(seed) & 7;
    exp_word = md[2];
    bus(1'b1, OFS_MODE, {28'h0, md});
    bus(1'b1, OFS_PCOUNT, {16'h0, pc});
    bus(1'b0, OFS_ACT, 32'h0);
    bus(1'b1, OFS_ACT, 32'h1 << s);
    i0 = n_irq;
    @(posedge core_clk);
    raise <= 8'h01 << s;
    @(posedge core_clk);
    raise <= 8'h00;
    wait_xfer(nx);
    bus(1'b0, OFS_PCOUNT, 32'h0);
    chk(rd, {16'h0, epc});
    bus(1'b0, OFS_BCOUNT, 32'h0);
    chk(rd, {16'h0, ebc});
    bus(1'b0, OFS_ACT, 32'h0);
    chk(rd[s], keep);
    chk(act_request[s], !keep);
    chk(n_irq - i0, !keep);
    if (!keep) begin
      chk(cpu_irq_source, s);
    end
    @(posedge core_clk);
    drop <= 8'hFF;
    @(posedge core_clk);
    drop <= 8'h00;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    exp_word = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    bus(1'b0, OFS_ACT, 32'h0);
    chk(rd, {24'h0, ACT_RESET});
    bus(1'b0, OFS_SWV, 32'h0);
    chk(rd, {24'h0, SWV_RESET});
    chk(vector_address, 16'h0400);
    bus(1'b0, 5'h01, 32'h0);
    chk(rd, 32'h0);
    // Word transfers need even addresses
    sa = $random(seed) & 32'h00FF_FFFE;
    da = $random(seed) & 32'h00FF_FFFE;
    bus(1'b1, OFS_SRC, sa);
    bus(1'b1, OFS_DST, da);
    bus(1'b0, OFS_DST, 32'h0);
    chk(rd, da);
    // Software start, not finished: enable falls back
    exp_word = 1'b1;
    bus(1'b1, OFS_MODE, 32'h4);
    bus(1'b1, OFS_PCOUNT, 32'h5);
    bus(1'b1, OFS_BCOUNT, 32'h1234);
    vec = $random(seed);
    bus(1'b1, OFS_SWV, {24'h0, 1'b1, vec});
    wait_xfer(1);
    chk(vector_address, exp_vec(vec));
    bus(1'b0, OFS_SWV, 32'h0);
    chk(rd, {25'h0, vec});
    bus(1'b0, OFS_PCOUNT, 32'h0);
    chk(rd, 32'h4);
    // Software start, count done: enable held, vector locked
    bus(1'b1, OFS_PCOUNT, 32'h1);
    bus(1'b1, OFS_SWV, {24'h0, 1'b1, vec});
    wait_xfer(1);
    chk(sw_end_irq, 1'b1);
    bus(1'b1, OFS_SWV, {24'h0, 1'b1, ~vec});
    bus(1'b0, OFS_SWV, 32'h0);
    chk(rd, {24'h0, 1'b1, vec});
    bus(1'b0, OFS_STAT, 32'h0);
    chk(rd[31:16], exp_vec(vec));
    bus(1'b1, OFS_MODE, 32'h4);
    bus(1'b0, OFS_SWV, 32'h0);
    chk(rd, {25'h0, vec});
    chk(sw_end_irq, 1'b0);
    // Interrupt activation across modes and count edges
    irq_case(4'h0, 16'h0002, 1, 16'h0001, 16'h1234, 1'b1);
    irq_case(4'h4, 16'h0001, 1, 16'h0000, 16'h1234, 1'b0);
    irq_case(4'h3, 16'h0000, 1, 16'hFFFF, 16'h1234, 1'b1);
    irq_case(4'h8, 16'h0005, 1, 16'h0004, 16'h1234, 1'b0);
    irq_case(4'h1, 16'h0201, 1, 16'h0202, 16'h1234, 1'b1);
    irq_case(4'h5, 16'h0300, 1, 16'h03FF, 16'h1234, 1'b1);
    bus(1'b1, OFS_BCOUNT, 32'h2);
    irq_case(4'h2, 16'h0303, 3, 16'h0303, 16'h0001, 1'b1);
    irq_case(4'h6, 16'h0303, 3, 16'h0303, 16'h0000, 1'b0);
    finish_test();
  end
endmodule
